/* File: dv/board_reset_model.sv */
// Board power-on source, slow oscillator and hard-reset pin model
`timescale 1ns/1ps
module board_reset_model #(
    parameter int HALF_CYCLES = 20
) (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic porReqB,
    input wire logic pinReqB,
    // Board reset lines and slow reference clock
    output logic powerOnResetB,
    output logic slowRefClock,
    output logic hardResetInB
);
    int phase = 0;
    // ----------------------------------------
    // Free-running slow oscillator, period shortened
    // ----------------------------------------
    always @(negedge clk) begin
        phase <= (phase == 2 * HALF_CYCLES - 1) ? 0 : phase + 1;
        slowRefClock <= (phase >= HALF_CYCLES);
    end
    // ----------------------------------------
    // Board reset lines follow the bench requests
    // ----------------------------------------
    assign powerOnResetB = porReqB;
    assign hardResetInB = pinReqB;
    // ----------------------------------------
    // Wait for slow ticks, return at a falling edge
    // ----------------------------------------
    task automatic waitTicks(input int n);
        repeat (n) @(posedge slowRefClock);
        @(negedge clk);
    endtask
endmodule // board_reset_model

/* File: dv/tb_reset_stretch_sequencer.sv */
// Testbench of the reset stretch sequencer
`timescale 1ns/1ps
module tb_reset_stretch_sequencer;
    import reset_seq_pkg::*;
    typedef struct {int lowTicks; logic hit;} row_t;
    localparam int POR_SIM = 5;
    logic clk = 1'b0;
    logic rst_b;
    logic porReqB;
    logic pinReqB;
    logic powerOnResetB;
    logic slowRefClock;
    logic hardResetInB;
    logic sdramResetB;
    logic internalSystemResetB;
    logic resetOutB;
    int failures = 0;
    int nTests = 0;
    // Pin low length in ticks, whether it must act
    row_t rows [4] = '{'{1, 1'b0}, '{2, 1'b0}, '{6, 1'b1}, '{8, 1'b1}};
    always #5 clk = ~clk;
    board_reset_model i_board_reset_model (
        .clk(clk),
        .porReqB(porReqB),
        .pinReqB(pinReqB),
        .powerOnResetB(powerOnResetB),
        .slowRefClock(slowRefClock),
        .hardResetInB(hardResetInB)
    );
    reset_stretch_sequencer #(.POR_CYCLES(POR_SIM)) i_reset_stretch_sequencer (
        .clk(clk),
        .rst_b(rst_b),
        .powerOnResetB(powerOnResetB),
        .slowRefClock(slowRefClock),
        .hardResetInB(hardResetInB),
        .sdramResetB(sdramResetB),
        .internalSystemResetB(internalSystemResetB),
        .resetOutB(resetOutB)
    );
    // ----------------------------------------
    // Comparison and closing tasks
    // ----------------------------------------
    task automatic check(input string what, input logic seen, input logic exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic checkOuts(input logic sd, input logic sys);
        check("sdramResetB", sdramResetB, sd);
        check("internalSystemResetB", internalSystemResetB, sys);
        check("resetOutB", resetOutB, sys);
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        porReqB = 1'b0;
        pinReqB = 1'b1;
        repeat (4) @(negedge clk);
        checkOuts(1'b0, 1'b0);
        rst_b = 1'b1;
        i_board_reset_model.waitTicks(3);
        porReqB = 1'b1;
        i_board_reset_model.waitTicks(10);
        checkOuts(1'b0, 1'b0);
        i_board_reset_model.waitTicks(4);
        checkOuts(1'b1, 1'b0);
        i_board_reset_model.waitTicks(7);
        checkOuts(1'b1, 1'b1);
        foreach (rows[i]) begin
            i_board_reset_model.waitTicks(1);
            pinReqB = 1'b0;
            i_board_reset_model.waitTicks(rows[i].lowTicks);
            checkOuts(!rows[i].hit, !rows[i].hit);
            pinReqB = 1'b1;
            i_board_reset_model.waitTicks(5);
            checkOuts(!rows[i].hit, !rows[i].hit);
            i_board_reset_model.waitTicks(4);
            checkOuts(1'b1, !rows[i].hit);
            i_board_reset_model.waitTicks(3);
            checkOuts(1'b1, !rows[i].hit);
            i_board_reset_model.waitTicks(4);
            checkOuts(1'b1, 1'b1);
        end
        // Power-on reset again in mid-run
        porReqB = 1'b0;
        repeat (8) @(negedge clk);
        checkOuts(1'b0, 1'b0);
        porReqB = 1'b1;
        i_board_reset_model.waitTicks(3);
        checkOuts(1'b0, 1'b0);
        i_board_reset_model.waitTicks(8);
        checkOuts(1'b0, 1'b0);
        i_board_reset_model.waitTicks(3);
        checkOuts(1'b1, 1'b0);
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule // tb_reset_stretch_sequencer

/* File: rtl/reset_seq_pkg.sv */
// Package of constants for the reset stretch sequencer
package reset_seq_pkg;
    // ----------------------------------------
    // Slow reference clock and timing
    // ----------------------------------------
    localparam int SYS_CLK_MHZ = 100;
    localparam int SLOW_CLK_HZ = 32000;
    localparam int POR_PULSE_MS = 300;
    localparam int POR_PULSE_SLOW_CYCLES = POR_PULSE_MS * SLOW_CLK_HZ / 1000;
    localparam int SDRAM_STRETCH_CYCLES = 7;
    localparam int SYS_STRETCH_CYCLES = 14;
    localparam int HARD_QUAL_CYCLES = 4;
    localparam int CNT_W = 16;
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_POR = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } seq_state_t;
endpackage

/* File: rtl/reset_stretch_if.sv */
// Interface carrying slow-tick events between stretcher parts
`timescale 1ns/1ps
interface reset_stretch_if;
    logic slowTick;
    logic srcActive;
    logic outActive;
    modport ctrl (output slowTick, output srcActive, input outActive);
    modport strc (input slowTick, input srcActive, output outActive);
endinterface

/* File: rtl/reset_stretch_sequencer.sv */
// Top of the reset stretch sequencer
`timescale 1ns/1ps
module reset_stretch_sequencer
    import reset_seq_pkg::*;
#(
    parameter int POR_CYCLES = POR_PULSE_SLOW_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Power-on reset and slow reference clock
    input wire logic powerOnResetB,
    input wire logic slowRefClock,
    // Hard-reset pin
    input wire logic hardResetInB,
    // Reset outputs
    output logic sdramResetB,
    output logic internalSystemResetB,
    output logic resetOutB
);
    logic [1:0] rstSync_r;
    logic rstSyncB;
    logic [2:0] clkSync_r;
    logic [2:0] porSync_r;
    logic [2:0] hardSync_r;
    logic slowLvl_r;
    logic slowTick;
    logic porIn_r;
    logic hardIn_r;
    logic [2:0] qualCnt_r;
    logic hardQual_r;
    logic [CNT_W-1:0] porCnt_r;
    seq_state_t state_r;
    logic porActive;
    logic srcActive;
    logic sdramRst_r;
    logic sysRst_r;

    reset_stretch_if sdLink ();
    reset_stretch_if syLink ();

    // ----------------------------------------
    // Reset release synchroniser
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstSyncB = rstSync_r[1];

    // ----------------------------------------
    // Input synchronisers, three stages
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            clkSync_r <= 3'b000;
            porSync_r <= 3'b000;
            hardSync_r <= 3'b111;
        end else begin
            clkSync_r <= {clkSync_r[1:0], slowRefClock};
            porSync_r <= {porSync_r[1:0], powerOnResetB};
            hardSync_r <= {hardSync_r[1:0], hardResetInB};
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            slowLvl_r <= 1'b0;
            porIn_r <= 1'b1;
            hardIn_r <= 1'b0;
        end else begin
            if (clkSync_r[2] == clkSync_r[1]) begin
                slowLvl_r <= clkSync_r[2];
            end
            if (porSync_r[2] == porSync_r[1]) begin
                porIn_r <= !porSync_r[2];
            end
            if (hardSync_r[2] == hardSync_r[1]) begin
                hardIn_r <= !hardSync_r[2];
            end
        end
    end
    assign slowTick = (clkSync_r[2] == clkSync_r[1]) && clkSync_r[2] && !slowLvl_r;

    // ----------------------------------------
    // Hard-reset qualifier
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            qualCnt_r <= 3'b000;
            hardQual_r <= 1'b0;
        end else if (!hardIn_r) begin
            qualCnt_r <= 3'b000;
            hardQual_r <= 1'b0;
        end else if (slowTick && !hardQual_r) begin
            if (qualCnt_r == 3'(HARD_QUAL_CYCLES - 1)) begin
                hardQual_r <= 1'b1;
            end
            qualCnt_r <= qualCnt_r + 3'd1;
        end
    end

    // ----------------------------------------
    // Internal power-on reset pulse
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            state_r <= ST_POR;
            porCnt_r <= '0;
        end else begin
            case (state_r)
                ST_POR: begin
                    if (!porIn_r) begin
                        state_r <= ST_HOLD;
                        porCnt_r <= '0;
                    end
                end
                ST_HOLD: begin
                    if (porIn_r) begin
                        state_r <= ST_POR;
                    end else if (slowTick) begin
                        if (porCnt_r == CNT_W'(POR_CYCLES - 1)) begin
                            state_r <= ST_RUN;
                        end
                        porCnt_r <= porCnt_r + CNT_W'(1);
                    end
                end
                ST_RUN: begin
                    if (porIn_r) begin
                        state_r <= ST_POR;
                    end
                end
                default: begin
                    state_r <= ST_POR;
                end
            endcase
        end
    end
    assign porActive = (state_r != ST_RUN);
    assign srcActive = porActive || hardQual_r;

    // ----------------------------------------
    // Output stretchers
    // ----------------------------------------
    assign sdLink.slowTick = slowTick;
    assign sdLink.srcActive = srcActive;
    assign syLink.slowTick = slowTick;
    assign syLink.srcActive = srcActive;

    reset_stretcher #(.STRETCH(SDRAM_STRETCH_CYCLES)) u_sdram (
        .clk(clk),
        .rstSyncB(rstSyncB),
        .link(sdLink.strc)
    );
    reset_stretcher #(.STRETCH(SYS_STRETCH_CYCLES)) u_sys (
        .clk(clk),
        .rstSyncB(rstSyncB),
        .link(syLink.strc)
    );

    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            sdramRst_r <= 1'b1;
            sysRst_r <= 1'b1;
        end else begin
            sdramRst_r <= sdLink.outActive;
            sysRst_r <= syLink.outActive;
        end
    end
    assign sdramResetB = !sdramRst_r;
    assign internalSystemResetB = !sysRst_r;
    assign resetOutB = !sysRst_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_srcFall;
        $fell(srcActive);
    endsequence

    property p_srcAsserts;
        @(posedge clk) disable iff (!rstSyncB) srcActive |=> sdramRst_r && sysRst_r;
    endproperty
    a_srcAsserts: assert property (p_srcAsserts) else $error("source did not assert resets");

    property p_sdHold;
        @(posedge clk) disable iff (!rstSyncB) s_srcFall |-> sdramRst_r [*2];
    endproperty
    a_sdHold: assert property (p_sdHold) else $error("sdram reset released early");

    property p_sysAfterSd;
        @(posedge clk) disable iff (!rstSyncB) sdramRst_r |-> sysRst_r;
    endproperty
    a_sysAfterSd: assert property (p_sysAfterSd) else $error("system reset ended first");

    property p_qualNeedsPin;
        @(posedge clk) disable iff (!rstSyncB) hardQual_r |-> hardIn_r || $past(hardIn_r);
    endproperty
    a_qualNeedsPin: assert property (p_qualNeedsPin) else $error("qualified without pin");

    property p_qualCount;
        @(posedge clk) disable iff (!rstSyncB) $rose(hardQual_r) |-> qualCnt_r == 3'd4;
    endproperty
    a_qualCount: assert property (p_qualCount) else $error("qualifier count wrong");

    property p_porCount;
        @(posedge clk) disable iff (!rstSyncB)
            (state_r == ST_RUN && $past(state_r) == ST_HOLD) |-> porCnt_r == CNT_W'(POR_CYCLES);
    endproperty
    a_porCount: assert property (p_porCount) else $error("power-on pulse length wrong");

    property p_pinMatch;
        @(posedge clk) disable iff (!rstSyncB) resetOutB == internalSystemResetB;
    endproperty
    a_pinMatch: assert property (p_pinMatch) else $error("reset pin differs");
endmodule // reset_stretch_sequencer

/* File: rtl/reset_stretcher.sv */
// Release stretcher counting slow reference clock ticks
`timescale 1ns/1ps
module reset_stretcher
    import reset_seq_pkg::*;
#(
    parameter int STRETCH = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstSyncB,
    // Control link
    reset_stretch_if.strc link
);
    logic [CNT_W-1:0] cnt_r;

    // ----------------------------------------
    // Hold output until STRETCH ticks after release
    // ----------------------------------------
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            cnt_r <= CNT_W'(STRETCH);
        end else if (link.srcActive) begin
            cnt_r <= CNT_W'(STRETCH);
        end else if (link.slowTick && cnt_r != '0) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    assign link.outActive = link.srcActive || (cnt_r != '0);
endmodule // reset_stretcher
